// *** common/esi_map.vh ***
// Constants shared by the Ethernet status indicator block.
`ifndef ESI_MAP_VH
`define ESI_MAP_VH

// Clock rate and flash timing.
`define ESI_CLK_FREQ_MHZ 50
`define ESI_FLASH_HALF_PERIOD_US 50000
`define ESI_FLASH_HALF_CYCLES (`ESI_FLASH_HALF_PERIOD_US * `ESI_CLK_FREQ_MHZ)
`define ESI_FLASH_CNT_W 22

// Register bus layout.
`define ESI_ADDR_W 8
`define ESI_DATA_W 32
`define ESI_OFF_CTRL 8'h00
`define ESI_OFF_STATE 8'h04
`define ESI_OFF_IRQ_STATUS 8'h08
`define ESI_OFF_IRQ_MASK 8'h0c

// Control register.
`define ESI_CTRL_W 1
`define ESI_CTRL_SOFT_STANDBY 0
`define ESI_CTRL_RST 1'b0

// Interrupt status and mask layout.
`define ESI_IRQ_W 5
`define ESI_IRQ_LINK_LOST 0
`define ESI_IRQ_LINK_UP 1
`define ESI_IRQ_JABBER 2
`define ESI_IRQ_POLARITY 3
`define ESI_IRQ_COLLISION 4
`define ESI_IRQ_RST 5'h00

// State register width.
`define ESI_STATE_W 10

// Synchroniser lanes.
`define ESI_SYNC_W 12
`define ESI_SI_STANDBY 0
`define ESI_SI_PORT_TP 1
`define ESI_SI_TP_TX 2
`define ESI_SI_TP_RX 3
`define ESI_SI_TP_COL 4
`define ESI_SI_AUI_TX 5
`define ESI_SI_AUI_RX 6
`define ESI_SI_AUI_COL 7
`define ESI_SI_LINK 8
`define ESI_SI_REVERSED 9
`define ESI_SI_JABBER 10
`define ESI_SI_FIX_EN 11
`define ESI_SYNC_RST 12'h000

`endif

// *** verilog/esi_indicators.v ***
// Status indicator outputs of a 10 Mb/s transceiver with an APB register slave.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "esi_map.vh"

module esi_indicators
#(
   parameter [31:0] FLASH_HALF_CYCLES = `ESI_FLASH_HALF_CYCLES,
   parameter CNT_W = `ESI_FLASH_CNT_W
)
(
   // Clock, reset and clock enable.
   input wire CLK_SYS,
   input wire NRST,
   input wire CE,
   // APB slave.
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [`ESI_ADDR_W-1:0] PADDR,
   input wire [`ESI_DATA_W-1:0] PWDATA,
   output reg [`ESI_DATA_W-1:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   // Conditions from the rest of the transceiver.
   input wire STANDBY,
   input wire PORT_TP_SEL,
   input wire TP_TX_ACT,
   input wire TP_RX_ACT,
   input wire TP_COL_ACT,
   input wire AUI_TX_ACT,
   input wire AUI_RX_ACT,
   input wire AUI_COL_ACT,
   input wire LINK_GOOD,
   input wire RX_PAIR_REVERSED,
   input wire JABBER_DETECT,
   input wire AUTO_POLARITY_FIX_ENABLE,
   // Indicator pins, each with an active-low output enable.
   output reg TRANSMIT_ACTIVITY_LED,
   output reg TRANSMIT_ACTIVITY_LED_OE_N,
   output reg RECEIVE_ACTIVITY_LED,
   output reg RECEIVE_ACTIVITY_LED_OE_N,
   output reg COLLISION_ACTIVITY_LED,
   output reg COLLISION_ACTIVITY_LED_OE_N,
   output reg LINK_GOOD_INDICATOR,
   output reg LINK_GOOD_INDICATOR_OE_N,
   output reg POLARITY_FAULT_INDICATOR,
   output reg POLARITY_FAULT_INDICATOR_OE_N,
   output reg JABBER_INDICATOR,
   output reg JABBER_INDICATOR_OE_N,
   // Polarity correction request and interrupt.
   output reg POLARITY_FIX_ACTIVE,
   output reg IRQ
);

   localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
   localparam [CNT_W-1:0] HALF_LAST = FLASH_HALF_CYCLES[CNT_W-1:0] - CNT_ONE;

   // ----------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------
   wire [`ESI_SYNC_W-1:0] sync_raw;
   reg [`ESI_SYNC_W-1:0] sync1_q;
   reg [`ESI_SYNC_W-1:0] sync2_q;

   assign sync_raw = {AUTO_POLARITY_FIX_ENABLE, JABBER_DETECT, RX_PAIR_REVERSED, LINK_GOOD,
                      AUI_COL_ACT, AUI_RX_ACT, AUI_TX_ACT, TP_COL_ACT, TP_RX_ACT, TP_TX_ACT,
                      PORT_TP_SEL, STANDBY};

   // The first stage feeds only the second stage, so a metastable value never
   // reaches a gate.
   // CE gates both stages together, so a frozen block never leaves a condition
   // half way through the pair.
   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         sync1_q <= `ESI_SYNC_RST;
         sync2_q <= `ESI_SYNC_RST;
      end
      else if (CE)
      begin
         sync1_q <= sync_raw;
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Conditions and port selection
   // ----------------------------------------------------------------
   reg [`ESI_CTRL_W-1:0] ctrl_q;
   wire standby;
   wire tp_mode;
   wire tx_act;
   wire rx_act;
   wire col_act;
   wire link_good;
   wire jabber;
   wire fix_active;

   // Soft standby from the control register acts exactly like the pin, so software
   // can dark every indicator without touching the board.
   assign standby = sync2_q[`ESI_SI_STANDBY] | ctrl_q[`ESI_CTRL_SOFT_STANDBY];
   assign tp_mode = sync2_q[`ESI_SI_PORT_TP];
   assign link_good = sync2_q[`ESI_SI_LINK];
   assign jabber = tp_mode & sync2_q[`ESI_SI_JABBER];
   assign tx_act = tp_mode ? sync2_q[`ESI_SI_TP_TX] : sync2_q[`ESI_SI_AUI_TX];
   assign rx_act = tp_mode ? sync2_q[`ESI_SI_TP_RX] : sync2_q[`ESI_SI_AUI_RX];
   // Jabber only exists on the pair transmitter, so it lights the LED in pair mode.
   assign col_act = (tp_mode ? sync2_q[`ESI_SI_TP_COL] : sync2_q[`ESI_SI_AUI_COL])
                    | jabber;
   assign fix_active = sync2_q[`ESI_SI_FIX_EN] & sync2_q[`ESI_SI_REVERSED];

   // ----------------------------------------------------------------
   // Flash divider
   // ----------------------------------------------------------------
   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] cnt_d;
   reg flash_q;
   reg flash_d;

   // Free running, so several LEDs that light together flash in step; the price
   // is that the first low phase after activity starts may be short.
   always @*
   begin
      cnt_d = cnt_q + CNT_ONE;
      flash_d = flash_q;
      if (cnt_q >= HALF_LAST)
      begin
         cnt_d = {CNT_W{1'b0}};
         flash_d = ~flash_q;
      end
   end

   // The phase flop resets to the off level, so the first half period after
   // reset is an off half on every activity LED.
   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         cnt_q <= {CNT_W{1'b0}};
         flash_q <= 1'b1;
      end
      else if (CE)
      begin
         cnt_q <= cnt_d;
         flash_q <= flash_d;
      end
   end

   // ----------------------------------------------------------------
   // Indicator pins
   // ----------------------------------------------------------------
   // Each level and its enable are flops, so a pin never glitches while a
   // condition moves between the synchroniser stages.
   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         TRANSMIT_ACTIVITY_LED <= 1'b1;
         TRANSMIT_ACTIVITY_LED_OE_N <= 1'b1;
         RECEIVE_ACTIVITY_LED <= 1'b1;
         RECEIVE_ACTIVITY_LED_OE_N <= 1'b1;
         COLLISION_ACTIVITY_LED <= 1'b1;
         COLLISION_ACTIVITY_LED_OE_N <= 1'b1;
         LINK_GOOD_INDICATOR <= 1'b1;
         LINK_GOOD_INDICATOR_OE_N <= 1'b1;
         POLARITY_FAULT_INDICATOR <= 1'b1;
         POLARITY_FAULT_INDICATOR_OE_N <= 1'b1;
         JABBER_INDICATOR <= 1'b0;
         JABBER_INDICATOR_OE_N <= 1'b1;
         POLARITY_FIX_ACTIVE <= 1'b0;
      end
      else if (CE)
      begin
         // An idle LED is released so the pull-up holds it in its high off state.
         TRANSMIT_ACTIVITY_LED <= tx_act ? flash_q : 1'b1;
         TRANSMIT_ACTIVITY_LED_OE_N <= standby | ~tx_act;
         RECEIVE_ACTIVITY_LED <= rx_act ? flash_q : 1'b1;
         RECEIVE_ACTIVITY_LED_OE_N <= standby | ~rx_act;
         COLLISION_ACTIVITY_LED <= col_act ? flash_q : 1'b1;
         COLLISION_ACTIVITY_LED_OE_N <= standby | ~col_act;
         LINK_GOOD_INDICATOR <= ~link_good;
         LINK_GOOD_INDICATOR_OE_N <= standby | ~tp_mode;
         // A failed link masks any reversal report.
         POLARITY_FAULT_INDICATOR <= ~link_good | ~fix_active;
         POLARITY_FAULT_INDICATOR_OE_N <= standby | ~tp_mode;
         JABBER_INDICATOR <= jabber;
         JABBER_INDICATOR_OE_N <= standby | ~tp_mode;
         POLARITY_FIX_ACTIVE <= fix_active & ~standby;
      end
   end

   // ----------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------
   // Events are rising edges of the synchronised conditions; link lost is a falling edge of link good.
   // The history flops reset to the idle levels, so no false event follows reset.
   reg link_prev_q;
   reg jabber_prev_q;
   reg fix_prev_q;
   reg col_prev_q;
   wire [`ESI_IRQ_W-1:0] events;

   assign events[`ESI_IRQ_LINK_LOST] = tp_mode & link_prev_q & ~link_good;
   assign events[`ESI_IRQ_LINK_UP] = tp_mode & ~link_prev_q & link_good;
   assign events[`ESI_IRQ_JABBER] = jabber & ~jabber_prev_q;
   assign events[`ESI_IRQ_POLARITY] = fix_active & ~fix_prev_q;
   assign events[`ESI_IRQ_COLLISION] = col_act & ~col_prev_q;

   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         link_prev_q <= 1'b0;
         jabber_prev_q <= 1'b0;
         fix_prev_q <= 1'b0;
         col_prev_q <= 1'b0;
      end
      else if (CE)
      begin
         link_prev_q <= link_good;
         jabber_prev_q <= jabber;
         fix_prev_q <= fix_active;
         col_prev_q <= col_act;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   reg [`ESI_IRQ_W-1:0] irq_status_q;
   reg [`ESI_IRQ_W-1:0] irq_status_d;
   reg [`ESI_IRQ_W-1:0] irq_mask_q;
   reg [`ESI_DATA_W-1:0] rdata_d;
   reg addr_ok;
   wire setup;
   wire access;
   wire wr_en;
   wire rd_en;
   wire [`ESI_STATE_W-1:0] state_bits;

   // PREADY is a flop set in the setup cycle, giving zero wait states.
   assign setup = PSEL & ~PENABLE;
   assign access = PSEL & PENABLE & PREADY;
   assign wr_en = access & PWRITE & addr_ok;
   assign rd_en = access & ~PWRITE & addr_ok;
   assign state_bits = {POLARITY_FIX_ACTIVE, flash_q, col_act, rx_act, tx_act, jabber,
                        sync2_q[`ESI_SI_REVERSED], link_good, tp_mode, standby};

   // Unmapped offsets answer with PSLVERR and take no write; the state register
   // is read only and silently ignores writes.
   always @*
   begin
      addr_ok = 1'b1;
      rdata_d = {`ESI_DATA_W{1'b0}};
      case (PADDR)
         `ESI_OFF_CTRL:
            rdata_d = {{(`ESI_DATA_W-`ESI_CTRL_W){1'b0}}, ctrl_q};
         `ESI_OFF_STATE:
            rdata_d = {{(`ESI_DATA_W-`ESI_STATE_W){1'b0}}, state_bits};
         `ESI_OFF_IRQ_STATUS:
            rdata_d = {{(`ESI_DATA_W-`ESI_IRQ_W){1'b0}}, irq_status_q};
         `ESI_OFF_IRQ_MASK:
            rdata_d = {{(`ESI_DATA_W-`ESI_IRQ_W){1'b0}}, irq_mask_q};
         default:
            addr_ok = 1'b0;
      endcase
   end

   // A read clears only the bits that it reported, so an event that lands between
   // the setup and the access cycle stays pending; an event in the access cycle
   // itself sets its bit again, so the set always wins.
   always @*
   begin
      irq_status_d = irq_status_q;
      if (rd_en && PADDR == `ESI_OFF_IRQ_STATUS)
      begin
         irq_status_d = irq_status_q & ~PRDATA[`ESI_IRQ_W-1:0];
      end
      irq_status_d = irq_status_d | events;
   end

   // IRQ is taken from the next status value, so it rises at the same edge as
   // its status bit and falls at the edge of the read that clears it.
   always @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= {`ESI_DATA_W{1'b0}};
         ctrl_q <= `ESI_CTRL_RST;
         irq_mask_q <= `ESI_IRQ_RST;
         irq_status_q <= `ESI_IRQ_RST;
         IRQ <= 1'b0;
      end
      else if (CE)
      begin
         PREADY <= setup;
         if (setup)
         begin
            PSLVERR <= ~addr_ok;
            PRDATA <= PWRITE ? {`ESI_DATA_W{1'b0}} : rdata_d;
         end
         else if (access)
         begin
            PSLVERR <= 1'b0;
            PRDATA <= {`ESI_DATA_W{1'b0}};
         end
         if (wr_en && PADDR == `ESI_OFF_CTRL)
         begin
            ctrl_q <= PWDATA[`ESI_CTRL_W-1:0];
         end
         if (wr_en && PADDR == `ESI_OFF_IRQ_MASK)
         begin
            irq_mask_q <= PWDATA[`ESI_IRQ_W-1:0];
         end
         irq_status_q <= irq_status_d;
         IRQ <= |(irq_status_d & irq_mask_q);
      end
   end

endmodule

// *** sim/esi_led_model.sv ***
// Pin-level model of the indicator LEDs and the status monitor inputs.
`timescale 1ns/100ps
module esi_led_model (
   input logic clk,
   input logic [5:0] drv,
   input logic [5:0] oe_n,
   output logic [5:0] pin
);
   // A floating status pin shows the inverse of its last level, so a stale value never passes.
   logic [5:0] last_q = 6'h3f;
   always @(posedge clk)
      for (int i = 0; i < 6; i++)
         if (!oe_n[i])
            last_q[i] <= drv[i];
   always_comb
      for (int i = 0; i < 6; i++)
         pin[i] = !oe_n[i] ? drv[i] : (i < 3 ? 1'b1 : !last_q[i]);
endmodule

// *** sim/esi_indicators_monitor.sv ***
// Assertions on the indicator pins and the bus handshake.
`timescale 1ns/100ps
module esi_indicators_monitor #(
   parameter [31:0] FLASH_HALF_CYCLES = 8,
   parameter CNT_W = 22
) (
   // Clock, reset and bus handshake.
   input logic CLK_SYS, NRST, PSEL, PENABLE, PREADY,
   // Conditions.
   input logic STANDBY, PORT_TP_SEL, TP_TX_ACT, AUI_TX_ACT, LINK_GOOD,
   input logic RX_PAIR_REVERSED, JABBER_DETECT, AUTO_POLARITY_FIX_ENABLE,
   // Pins.
   input logic TRANSMIT_ACTIVITY_LED, TRANSMIT_ACTIVITY_LED_OE_N,
   input logic RECEIVE_ACTIVITY_LED, RECEIVE_ACTIVITY_LED_OE_N,
   input logic COLLISION_ACTIVITY_LED, COLLISION_ACTIVITY_LED_OE_N,
   input logic LINK_GOOD_INDICATOR, LINK_GOOD_INDICATOR_OE_N,
   input logic POLARITY_FAULT_INDICATOR, POLARITY_FAULT_INDICATOR_OE_N,
   input logic JABBER_INDICATOR, JABBER_INDICATOR_OE_N
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   wire [5:0] oe = {JABBER_INDICATOR_OE_N, POLARITY_FAULT_INDICATOR_OE_N,
      LINK_GOOD_INDICATOR_OE_N, COLLISION_ACTIVITY_LED_OE_N,
      RECEIVE_ACTIVITY_LED_OE_N, TRANSMIT_ACTIVITY_LED_OE_N};
   wire [5:0] lv = {JABBER_INDICATOR, POLARITY_FAULT_INDICATOR, LINK_GOOD_INDICATOR,
      COLLISION_ACTIVITY_LED, RECEIVE_ACTIVITY_LED, TRANSMIT_ACTIVITY_LED};
   wire tx_sel = PORT_TP_SEL ? TP_TX_ACT : AUI_TX_ACT;
   wire [1:0] mode = {STANDBY, PORT_TP_SEL};
   // Length of the present transmit LED level; a stuck divider makes it grow past a half period.
   logic [CNT_W-1:0] run_q;
   logic lv_q;
   always @(posedge CLK_SYS or negedge NRST)
      if (!NRST)
      begin
         run_q <= '0;
         lv_q <= 1'b1;
      end
      else
      begin
         lv_q <= lv[0];
         run_q <= oe[0] ? '0 : (lv[0] != lv_q) ? 1 : run_q + 1'b1;
      end
   chk_standby_float: assert property ($past(STANDBY, 3) |-> &oe)
      else $error("indicator driven in standby");
   chk_aui_float: assert property (!$past(PORT_TP_SEL, 3) |-> &oe[5:3])
      else $error("status pin driven with attachment port");
   chk_link_level: assert property ($past(mode, 3) == 2'b01 |->
      !oe[3] && lv[3] == !$past(LINK_GOOD, 3)) else $error("link pin wrong");
   chk_polarity_level: assert property (
      $past(mode, 3) == 2'b01 |->
      !oe[4] && lv[4] == !$past(LINK_GOOD && AUTO_POLARITY_FIX_ENABLE && RX_PAIR_REVERSED, 3))
      else $error("polarity pin wrong");
   chk_jabber_level: assert property ($past(mode, 3) == 2'b01 |->
      !oe[5] && lv[5] == $past(JABBER_DETECT, 3)) else $error("jabber pin wrong");
   chk_idle_release: assert property (!$past(tx_sel, 3) |-> oe[0] && lv[0])
      else $error("idle transmit LED not released");
   chk_tx_driven: assert property ($past({STANDBY, tx_sel}, 3) == 2'b01 |-> !oe[0])
      else $error("active transmit LED not driven");
   chk_flash_half: assert property (run_q <= FLASH_HALF_CYCLES)
      else $error("flash half period too long");
   chk_same_phase: assert property (
      oe[2:0] == 3'h0 |-> lv[2:0] == {3{lv[0]}}) else $error("activity LEDs out of phase");
   chk_jabber_collision: assert property (
      $past({mode, JABBER_DETECT}, 3) == 3'b011 |-> !oe[2])
      else $error("collision LED idle during jabber");
   chk_bus_ready: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   cover property (!oe[0] && $fell(lv[0]));
   cover property (!oe[5] && lv[5]);
   cover property (&oe && $past(STANDBY, 3));
endmodule
bind esi_indicators esi_indicators_monitor #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES),
   .CNT_W(CNT_W)) u_monitor (.*);

// *** sim/esi_indicators_bench.sv ***
// Self-checking bench for the status indicator block.
`timescale 1ns/100ps
`include "esi_map.vh"
module esi_indicators_bench;
   localparam int HALF = 8;
   logic CLK_SYS = 0, NRST = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic PREADY, PSLVERR, POLARITY_FIX_ACTIVE, IRQ;
   logic STANDBY = 0, PORT_TP_SEL = 0, TP_TX_ACT = 0, TP_RX_ACT = 0, TP_COL_ACT = 0;
   logic AUI_TX_ACT = 0, AUI_RX_ACT = 0, AUI_COL_ACT = 0, LINK_GOOD = 0;
   logic RX_PAIR_REVERSED = 0, JABBER_DETECT = 0, AUTO_POLARITY_FIX_ENABLE = 0;
   logic TRANSMIT_ACTIVITY_LED, TRANSMIT_ACTIVITY_LED_OE_N;
   logic RECEIVE_ACTIVITY_LED, RECEIVE_ACTIVITY_LED_OE_N;
   logic COLLISION_ACTIVITY_LED, COLLISION_ACTIVITY_LED_OE_N;
   logic LINK_GOOD_INDICATOR, LINK_GOOD_INDICATOR_OE_N;
   logic POLARITY_FAULT_INDICATOR, POLARITY_FAULT_INDICATOR_OE_N;
   logic JABBER_INDICATOR, JABBER_INDICATOR_OE_N;
   logic [5:0] pin;
   int n_errors = 0, samples_checked = 0, cyc = 0;
   wire [5:0] oe = {JABBER_INDICATOR_OE_N, POLARITY_FAULT_INDICATOR_OE_N,
      LINK_GOOD_INDICATOR_OE_N, COLLISION_ACTIVITY_LED_OE_N,
      RECEIVE_ACTIVITY_LED_OE_N, TRANSMIT_ACTIVITY_LED_OE_N};
   wire [5:0] lv = {JABBER_INDICATOR, POLARITY_FAULT_INDICATOR, LINK_GOOD_INDICATOR,
      COLLISION_ACTIVITY_LED, RECEIVE_ACTIVITY_LED, TRANSMIT_ACTIVITY_LED};
   esi_indicators #(.FLASH_HALF_CYCLES(HALF)) dut (.*);
   esi_led_model u_leds (.clk(CLK_SYS), .drv(lv), .oe_n(oe), .pin(pin));
   always #10 CLK_SYS = ~CLK_SYS;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic end_sim;
      $display("checks=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask
   // Request stays put until ready is seen high at an edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge CLK_SYS);
      PSEL <= 1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK_SYS);
      PENABLE <= 1;
      do @(posedge CLK_SYS); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] d;
      logic e;
      apb(0, a, 0, d, e);
      chk(d, exp);
      chk(e, exp_err);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1, a, d, x, e);
   endtask
   // A 32-cycle window holds exactly two flash periods, so half of it is low.
   task automatic flash(input int k);
      int lows;
      lows = 0;
      tick(5);
      repeat (4 * HALF)
      begin
         @(posedge CLK_SYS);
         lows += (oe[k] === 1'b0 && lv[k] === 1'b0);
      end
      chk(lows, 2 * HALF);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_registers;
      {PORT_TP_SEL, TP_TX_ACT, LINK_GOOD, JABBER_DETECT, STANDBY} <= 5'h1f;
      tick(5);
      chk(oe, 6'h3f);
      rd_chk(`ESI_OFF_CTRL, 0, 0);
      rd_chk(`ESI_OFF_IRQ_MASK, 0, 0);
      wr(`ESI_OFF_CTRL, 1);
      rd_chk(`ESI_OFF_CTRL, 1, 0);
      wr(`ESI_OFF_CTRL, 0);
      rd_chk(8'h10, 0, 1);
      STANDBY <= 0;
   endtask
   task automatic s_pair_status;
      for (int i = 0; i < 16; i++)
      begin
         {LINK_GOOD, AUTO_POLARITY_FIX_ENABLE, RX_PAIR_REVERSED, JABBER_DETECT} <= i[3:0];
         tick(5);
         chk(oe[5:3], 0);
         chk(lv[3], !i[3]);
         chk(lv[4], i[3:1] != 3'b111);
         chk(lv[5], i[0]);
         chk(POLARITY_FIX_ACTIVE, i[2:1] == 2'b11);
      end
      PORT_TP_SEL <= 0;
      tick(5);
      chk(oe[5:3], 3'h7);
   endtask
   task automatic s_activity;
      JABBER_DETECT <= 0;
      for (int p = 0; p < 2; p++)
         for (int k = 0; k < 3; k++)
         begin
            PORT_TP_SEL <= p[0];
            {TP_COL_ACT, TP_RX_ACT, TP_TX_ACT} <= p ? 3'b1 << k : 3'h7;
            {AUI_COL_ACT, AUI_RX_ACT, AUI_TX_ACT} <= p ? 3'h7 : 3'b1 << k;
            flash(k);
            chk({oe[2:0], pin[2:0]} | {2{3'b1 << k}}, 6'h3f);
         end
      {TP_COL_ACT, TP_RX_ACT, TP_TX_ACT} <= 3'h7;
      flash(1);
      {TP_COL_ACT, TP_RX_ACT, TP_TX_ACT, JABBER_DETECT} <= 4'h1;
      flash(2);
      JABBER_DETECT <= 0;
   endtask
   task automatic s_irq;
      logic [31:0] d;
      logic e;
      LINK_GOOD <= 1;
      tick(8);
      apb(0, `ESI_OFF_IRQ_STATUS, 0, d, e);
      wr(`ESI_OFF_IRQ_MASK, 32'h1 << `ESI_IRQ_LINK_LOST);
      LINK_GOOD <= 0;
      tick(6);
      chk(IRQ, 1);
      rd_chk(`ESI_OFF_IRQ_STATUS, 32'h1 << `ESI_IRQ_LINK_LOST, 0);
      tick(2);
      chk(IRQ, 0);
      LINK_GOOD <= 1;
      tick(6);
      chk(IRQ, 0);
      rd_chk(`ESI_OFF_IRQ_STATUS, 32'h1 << `ESI_IRQ_LINK_UP, 0);
      // State is read only: pair mode, link, reversed and fix active; phase bit masked.
      wr(`ESI_OFF_STATE, 32'h3ff);
      apb(0, `ESI_OFF_STATE, 0, d, e);
      chk(d & ~(32'h1 << 8), 32'h20e);
      chk(e, 0);
   endtask
   initial
   begin
      tick(10);
      NRST <= 1;
      s_registers;
      s_pair_status;
      s_activity;
      s_irq;
      end_sim;
   end
   always @(posedge CLK_SYS)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors++;
         end_sim;
      end
   end
endmodule
